// *** rtl/hma_pkg.sv ***
// Purpose: Shared constants and types of the hierarchical memory arbiter
// Assumes: 20 MHz arbiter clock, APB register access with 32-bit data
// Notes: All offsets are byte addresses of aligned 32-bit words
package hma_pkg;

   // Requesting units, one grant line each
   localparam int NUM_UNITS = 12;
   localparam int U_CPU_MMIO = 0;
   localparam int U_DCACHE = 1;
   localparam int U_ICACHE = 2;
   localparam int U_VIDEO_OUT = 3;
   localparam int U_IMAGE_COP = 4;
   localparam int U_VIDEO_IN = 5;
   localparam int U_PCI = 6;
   localparam int U_VLD = 7;
   localparam int U_AUDIO_IN = 8;
   localparam int U_AUDIO_OUT = 9;
   localparam int U_DESCRAMBLER = 10;
   localparam int U_BOOT = 11;
   localparam logic [11:0] CPU_GROUP_MASK = 12'h007;
   localparam logic [11:0] LOWEST_GROUP_MASK = 12'hf80;

   // Units that own a priority raise delay, in fixed high-priority order
   localparam int NUM_RAISE = 4;
   localparam int RAISE_IDX [NUM_RAISE] = '{U_VIDEO_OUT, U_VIDEO_IN, U_PCI, U_VLD};
   localparam int RAISE_FIELD_W = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_WEIGHT = 8'h00;
   localparam logic [7:0] OFS_RAISE = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_RATIO = 8'h0c;
   localparam logic [7:0] OFS_REFINT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_INTEN = 8'h18;
   localparam logic [7:0] OFS_INTCLR = 8'h1c;
   localparam logic [7:0] OFS_STATE = 8'h20;
   localparam logic [7:0] OFS_BYTES = 8'h24;

   // Reset values
   localparam logic [17:0] WEIGHT_RST = 18'h00000;
   localparam logic [15:0] RAISE_RST = 16'h0000;
   localparam logic [11:0] ENABLE_RST = 12'hfff;
   localparam logic [2:0] RATIO_RST = 3'h0;
   localparam logic [4:0] INTEN_RST = 5'h00;

   // Processor-to-memory clock ratio codes
   localparam logic [2:0] RATIO_1_1 = 3'h0;
   localparam logic [2:0] RATIO_5_4 = 3'h1;
   localparam logic [2:0] RATIO_4_3 = 3'h2;
   localparam logic [2:0] RATIO_3_2 = 3'h3;
   localparam logic [2:0] RATIO_2_1 = 3'h4;

   // Status bit positions: real-time unit faults then refresh done
   localparam int ST_W = 5;
   localparam int ST_FAULT_LSB = 0;
   localparam int ST_REFRESH = 4;

   // Bus timing in memory cycles; raise tick in processor cycles, block size in bytes
   localparam logic [4:0] TXN_CYCLES = 5'd20;
   localparam logic [4:0] FIRST_ACCESS_EXTRA = 5'd10;
   localparam logic [4:0] REFRESH_CYCLES = 5'd19;
   localparam int RAISE_TICK = 16;
   localparam logic [31:0] XFER_BYTES = 32'h00000040;

   // Refresh spacing: refresh bursts per retention window
   localparam int CLK_PERIOD_NS = 50;
   localparam int REFRESH_WINDOW_NS = 64_000_000;
   localparam int REFRESH_BURSTS = 4096;
   localparam int REFRESH_SPACING = REFRESH_WINDOW_NS / (REFRESH_BURSTS * CLK_PERIOD_NS);
   localparam logic [15:0] REFINT_RST = 16'(REFRESH_SPACING);

   // Weight control layout, most significant field first
   typedef struct packed {
      logic [1:0] cpu_w;
      logic [1:0] l2_w;
      logic [1:0] vo_w;
      logic [1:0] l3_w;
      logic [1:0] icp_w;
      logic [1:0] l4_w;
      logic vi_w;
      logic [1:0] l5_w;
      logic [1:0] pci_w;
      logic l6_w;
   } hma_wctl_t;

endpackage : hma_pkg

// *** rtl/hma_wrr_level.sv ***
// Purpose: One weighted round-robin level: own unit against lower group
// Assumes: take is high only when the grant passed through this level
// Notes: Credits reload once both sides have spent their weight
module hma_wrr_level
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [2:0] own_w,
   input wire logic [2:0] low_w,
   input wire logic own_req,
   input wire logic low_req,
   input wire logic take,
   output logic pick_own
);

   logic [2:0] own_used; // Grants spent by own unit this round
   logic [2:0] low_used; // Grants spent by lower group this round
   logic spent;          // Both sides out of credit

   assign spent = (own_used >= own_w) && (low_used >= low_w);

   // Side selection for the current arbitration point
   always_comb
   begin
      if (!low_req)
         pick_own = 1'b1; // Lone requester wins regardless of weight
      else if (!own_req)
         pick_own = 1'b0; // Lone lower group wins
      else if (spent || own_used < own_w)
         pick_own = 1'b1; // Own credit left, or a fresh round
      else
         pick_own = 1'b0; // Own credit spent, lower side takes its share
   end

   // Credit accounting per grant taken through this level
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         own_used <= 3'h0;
         low_used <= 3'h0;
      end
      else if (ce && take)
      begin
         if (spent)
         begin
            // New round starts with this grant already counted
            own_used <= pick_own ? 3'h1 : 3'h0;
            low_used <= pick_own ? 3'h0 : 3'h1;
         end
         else if (pick_own)
            // Saturate so a long lone run cannot wrap back to fresh credit
            own_used <= (own_used >= own_w) ? own_used : own_used + 3'h1;
         else
            low_used <= (low_used >= low_w) ? low_used : low_used + 3'h1;
      end
   end

endmodule : hma_wrr_level

// *** rtl/hma_arbiter.sv ***
// Purpose: Hierarchical weighted memory arbiter with APB register access
// Assumes: Requests and fault pulses come from logic on CLK
// Notes: One grant per arbitration point; bus busy time is counted inside
//
// Implementation choices: register access over APB and the placing of the registers.

// Summary of operation
// - Levels one to five share grants by their two weights
// - Waiting unit served within its level bound
// - Disabled unit drops out; share passes on
// - Each transaction holds the bus 20 cycles
// - First reordered processor access adds 10 cycles
// - Refresh holds bus 19 cycles per interval
// - 4096 refreshes every 64 ms are reserved
// - Raise after 16 processor cycles per count
// - Only four units have a raise delay
// - Raise delay scaled by processor clock ratio
// - Worst wait bounded by grants, refresh, delay
// - Minimum bandwidth follows request ratio and delay
// - Real-time units flag buffer over/underflow
// - Six nested levels, unit against lower group
// - Lowest level: decoder weight two, others one
// - Processor sources fixed priority, one request
// - Reset weights zero, meaning weight one
module hma_arbiter
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [11:0] REQ,
   input wire logic CPU_REORDER,
   input wire logic [3:0] RT_FAULT,
   output logic [11:0] GNT,
   output logic REFRESH,
   output logic INT
);

   // Known register offsets
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == hma_pkg::OFS_WEIGHT) || (a == hma_pkg::OFS_RAISE) ||
                (a == hma_pkg::OFS_ENABLE) || (a == hma_pkg::OFS_RATIO) ||
                (a == hma_pkg::OFS_REFINT) || (a == hma_pkg::OFS_STATUS) ||
                (a == hma_pkg::OFS_INTEN) || (a == hma_pkg::OFS_INTCLR) ||
                (a == hma_pkg::OFS_STATE) || (a == hma_pkg::OFS_BYTES);
   endfunction : reg_hit

   // Lowest set bit as a one-hot vector
   function automatic logic [11:0] first_one(input logic [11:0] x);
      first_one = x & (~x + 12'h001);
   endfunction : first_one

   // Weights of the form 1,2,3,4 and of the form 1,3,5,7
   function automatic logic [2:0] lin_w(input logic [1:0] c);
      lin_w = {1'b0, c} + 3'h1;
   endfunction : lin_w

   function automatic logic [2:0] odd_w(input logic [1:0] c);
      odd_w = {c, 1'b1};
   endfunction : odd_w

   // Raise delay in memory cycles: ceil(16 * count / ratio)
   function automatic logic [9:0] raise_cycles(input logic [3:0] r, input logic [2:0] code);
      logic [9:0] base;
      base = {2'h0, r, 4'h0};
      case (code)
         hma_pkg::RATIO_5_4: raise_cycles = 10'((base * 4 + 4) / 5);
         hma_pkg::RATIO_4_3: raise_cycles = 10'((base * 3 + 3) / 4);
         hma_pkg::RATIO_3_2: raise_cycles = 10'((base * 2 + 2) / 3);
         hma_pkg::RATIO_2_1: raise_cycles = 10'((base + 1) / 2);
         default: raise_cycles = base; // Equal clocks
      endcase
   endfunction : raise_cycles

   logic [17:0] wctl;          // Weight control register
   hma_pkg::hma_wctl_t wf;     // Weight fields
   logic [15:0] raise;         // Priority raise delay register
   logic [11:0] enable;        // Unit enable mask
   logic [2:0] ratio;          // Clock ratio code
   logic [15:0] refint;        // Refresh interval in cycles
   logic [4:0] status;         // Sticky event flags
   logic [4:0] inten;          // Interrupt enables
   logic [31:0] bytes;         // Bytes granted since reset
   logic [31:0] rd;            // Read mux
   logic wr;                   // Write takes effect
   logic [4:0] busy_cnt;       // Remaining bus cycles
   logic ref_pend;             // Refresh waiting for the bus
   logic [15:0] ref_cnt;       // Refresh interval timer
   logic last_cpu;             // Last grant went to the processor
   logic [11:0] m;             // Enabled requests
   logic [11:0] hi;            // Raised requests
   logic [11:0] next_gnt;      // Winner of this point
   logic arb_point;            // Bus free
   logic fire;                 // A grant is issued now
   logic [4:0] status_set;     // Events this cycle
   logic [4:0] status_clr;     // Clear mask written now
   logic [4:0] own_req;        // Own unit request per level
   logic [5:0] grp;            // Group requests per level
   logic [2:0] own_w [5];      // Own weight per level
   logic [2:0] low_w [5];      // Lower weight per level
   logic [4:0] pick;           // Level chose own unit
   logic [5:0] reach;          // Decision reached this level
   logic [1:0] used6 [5];      // Lowest level credits spent
   logic [4:0] m6;             // Lowest level requests
   logic [4:0] cand6;          // Lowest level units with credit
   logic [4:0] elig6;          // Lowest level eligible
   logic reload6;              // Lowest level round ends

   assign wf = hma_pkg::hma_wctl_t'(wctl);
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   assign m = REQ & enable;
   assign arb_point = (busy_cnt == 5'h00);
   assign fire = CE && arb_point && !ref_pend && (|m);

   // APB answer: ready one cycle into the access phase
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end
      else if (CE)
      begin
         if (PSEL && PENABLE && !PREADY)
         begin
            PREADY <= 1'b1;
            PSLVERR <= !reg_hit(PADDR);
            PRDATA <= PWRITE ? 32'h00000000 : rd;
         end
         else
         begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
         end
      end
   end

   // Read mux; write-only and unmapped read zero
   always_comb
   begin
      rd = 32'h00000000;
      unique case (PADDR)
         hma_pkg::OFS_WEIGHT: rd = {14'h0000, wctl};
         hma_pkg::OFS_RAISE: rd = {16'h0000, raise};
         hma_pkg::OFS_ENABLE: rd = {20'h00000, enable};
         hma_pkg::OFS_RATIO: rd = {29'h00000000, ratio};
         hma_pkg::OFS_REFINT: rd = {16'h0000, refint};
         hma_pkg::OFS_STATUS: rd = {27'h0000000, status};
         hma_pkg::OFS_INTEN: rd = {27'h0000000, inten};
         hma_pkg::OFS_STATE: rd = {13'h0000, ref_pend, busy_cnt, 1'b0, GNT};
         hma_pkg::OFS_BYTES: rd = bytes;
         default: rd = 32'h00000000;
      endcase
   end

   // Configuration registers
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         wctl <= hma_pkg::WEIGHT_RST;
         raise <= hma_pkg::RAISE_RST;
         enable <= hma_pkg::ENABLE_RST;
         ratio <= hma_pkg::RATIO_RST;
         refint <= hma_pkg::REFINT_RST;
         inten <= hma_pkg::INTEN_RST;
      end
      else if (CE && wr)
      begin
         unique case (PADDR)
            hma_pkg::OFS_WEIGHT: wctl <= PWDATA[17:0];
            hma_pkg::OFS_RAISE: raise <= PWDATA[15:0];
            hma_pkg::OFS_ENABLE: enable <= PWDATA[11:0];
            hma_pkg::OFS_RATIO: ratio <= PWDATA[2:0];
            hma_pkg::OFS_REFINT: refint <= PWDATA[15:0];
            hma_pkg::OFS_INTEN: inten <= PWDATA[4:0];
            default: ; // Read-only, unmapped, or INTCLR, which clears the flags below
         endcase
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   assign status_set = {REFRESH, RT_FAULT};
   assign status_clr = (wr && PADDR == hma_pkg::OFS_INTCLR) ? PWDATA[4:0] : 5'h00;

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         status <= 5'h00;
         INT <= 1'b0;
      end
      else if (CE)
      begin
         status <= (status & ~status_clr) | status_set;
         INT <= |(status & inten);
      end
   end

   // Weighted levels one to five; own weight against lower group
   assign own_req = {m[hma_pkg::U_PCI], m[hma_pkg::U_VIDEO_IN], m[hma_pkg::U_IMAGE_COP],
                     m[hma_pkg::U_VIDEO_OUT], |(m & hma_pkg::CPU_GROUP_MASK)};
   assign grp[5] = |(m & hma_pkg::LOWEST_GROUP_MASK);
   assign own_w[0] = lin_w(wf.cpu_w);
   assign low_w[0] = lin_w(wf.l2_w);
   assign own_w[1] = odd_w(wf.vo_w);
   assign low_w[1] = odd_w(wf.l3_w);
   assign own_w[2] = odd_w(wf.icp_w);
   assign low_w[2] = odd_w(wf.l4_w);
   assign own_w[3] = lin_w({1'b0, wf.vi_w});
   assign low_w[3] = odd_w(wf.l5_w);
   assign own_w[4] = odd_w(wf.pci_w);
   assign low_w[4] = lin_w({1'b0, wf.l6_w});
   assign reach[0] = 1'b1;

   genvar k;
   generate
      for (k = 0; k < 5; k++)
      begin : g_level
         assign grp[k] = own_req[k] | grp[k + 1];
         assign reach[k + 1] = reach[k] & ~pick[k];
         // Nested levels, each against all below it
         hma_wrr_level u_level
         (
            .clk(CLK),
            .rst_n(RESET_N),
            .ce(CE),
            .own_w(own_w[k]),
            .low_w(low_w[k]),
            .own_req(own_req[k]),
            .low_req(grp[k + 1]),
            .take(fire && !(|hi) && reach[k]),
            .pick_own(pick[k])
         );
      end
   endgenerate

   // Raise timers for the four units that own a delay
   genvar j;
   generate
      for (j = 0; j < hma_pkg::NUM_RAISE; j++)
      begin : g_raise
         localparam int U = hma_pkg::RAISE_IDX[j];
         logic [9:0] thr; // Raise threshold in memory cycles
         logic [9:0] wait_cnt; // Cycles waited at low priority, one driver per unit
         assign thr = raise_cycles(raise[j * hma_pkg::RAISE_FIELD_W +: 4], ratio);
         // Zero delay means never raised, like units without a delay
         assign hi[U] = m[U] && (thr != 10'h000) && (wait_cnt >= thr);
         always_ff @(posedge CLK)
         begin
            if (!RESET_N)
               wait_cnt <= 10'h000;
            else if (CE)
            begin
               if (!m[U] || (fire && next_gnt[U]))
                  wait_cnt <= 10'h000;
               else if (wait_cnt != 10'h3ff)
                  wait_cnt <= wait_cnt + 10'h001;
            end
         end
      end
   endgenerate

   assign hi[hma_pkg::U_CPU_MMIO] = 1'b0;
   assign hi[hma_pkg::U_DCACHE] = 1'b0;
   assign hi[hma_pkg::U_ICACHE] = 1'b0;
   assign hi[hma_pkg::U_IMAGE_COP] = 1'b0;
   assign hi[11:8] = 4'h0;

   // Lowest level: decoder weight two, the rest weight one
   assign m6 = m[11:7];
   always_comb
   begin
      cand6 = 5'h00;
      for (int i = 0; i < 5; i++)
         cand6[i] = m6[i] && (used6[i] < ((i == 0) ? 2'h2 : 2'h1));
   end
   assign reload6 = (cand6 == 5'h00);
   assign elig6 = reload6 ? m6 : cand6;

   // Winner selection
   always_comb
   begin
      next_gnt = 12'h000;
      if (|hi)
         next_gnt = first_one(hi); // Raised requests first
      else if (pick[0])
         next_gnt = first_one(m & hma_pkg::CPU_GROUP_MASK);
      else if (reach[1] && pick[1])
         next_gnt[hma_pkg::U_VIDEO_OUT] = 1'b1;
      else if (reach[2] && pick[2])
         next_gnt[hma_pkg::U_IMAGE_COP] = 1'b1;
      else if (reach[3] && pick[3])
         next_gnt[hma_pkg::U_VIDEO_IN] = 1'b1;
      else if (reach[4] && pick[4])
         next_gnt[hma_pkg::U_PCI] = 1'b1;
      else
         next_gnt = first_one({elig6, 7'h00});
   end

   // Lowest level credit accounting
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         for (int i = 0; i < 5; i++)
            used6[i] <= 2'h0;
      end
      else if (CE && fire && |(next_gnt & hma_pkg::LOWEST_GROUP_MASK))
      begin
         for (int i = 0; i < 5; i++)
         begin
            if (next_gnt[i + 7])
               used6[i] <= reload6 ? 2'h1 : used6[i] + 2'h1;
            else if (reload6)
               used6[i] <= 2'h0;
         end
      end
   end

   // Refresh timer: one refresh per programmed interval
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         ref_cnt <= hma_pkg::REFINT_RST;
         ref_pend <= 1'b0;
      end
      else if (CE)
      begin
         if (ref_cnt == 16'h0000)
            ref_cnt <= refint;
         else
            ref_cnt <= ref_cnt - 16'h0001;
         if (ref_cnt == 16'h0000)
            ref_pend <= 1'b1; // Timer wins over a same-cycle start
         else if (arb_point)
            ref_pend <= 1'b0;
      end
   end

   // Grants, bus occupancy and byte count
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         GNT <= 12'h000;
         REFRESH <= 1'b0;
         busy_cnt <= 5'h00;
         last_cpu <= 1'b0;
         bytes <= 32'h00000000;
      end
      else if (CE)
      begin
         GNT <= fire ? next_gnt : 12'h000;
         REFRESH <= arb_point && ref_pend;
         if (arb_point && ref_pend)
            busy_cnt <= hma_pkg::REFRESH_CYCLES - 5'h01; // Refresh first
         else if (fire && pick[0] && !(|hi) && !last_cpu && CPU_REORDER)
            busy_cnt <= hma_pkg::TXN_CYCLES + hma_pkg::FIRST_ACCESS_EXTRA - 5'h01;
         else if (fire)
            busy_cnt <= hma_pkg::TXN_CYCLES - 5'h01;
         else if (!arb_point)
            busy_cnt <= busy_cnt - 5'h01;
         if (fire)
         begin
            last_cpu <= |(next_gnt & hma_pkg::CPU_GROUP_MASK);
            bytes <= bytes + hma_pkg::XFER_BYTES;
         end
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence quiet8_s;
      (GNT == 12'h000) [*8];
   endsequence

   grant_onehot_a: assert property ($onehot0(GNT))
      else $error("more than one grant");
   grant_enabled_a: assert property (|GNT |-> (GNT & ~$past(m)) == 12'h000)
      else $error("grant to a unit not requesting or disabled");
   txn_hold_a: assert property ((|GNT && CE) |=> quiet8_s)
      else $error("grant during transaction");
   refresh_hold_a: assert property ((REFRESH && CE) |=> quiet8_s)
      else $error("grant during refresh");
   lone_grant_a: assert property ((CE && arb_point && !ref_pend && |m) |=> |GNT)
      else $error("requester not granted at free point");
   raised_first_a: assert property ((fire && |hi) |=> |(GNT & $past(hi)))
      else $error("raised request not served first");
   cpu_order_a: assert property (GNT[hma_pkg::U_ICACHE] |-> !$past(m[1]) && !$past(m[0]))
      else $error("processor sources out of order");
   fault_sticky_a: assert property ((CE && RT_FAULT[0]) |=> status[0] [*2])
      else $error("fault flag lost");
   bytes_step_a: assert property ((fire) |=> bytes == $past(bytes) + hma_pkg::XFER_BYTES)
      else $error("byte count not advanced by one block");
   reset_weight_a: assert property (disable iff (1'b0) !RESET_N |=> wctl == 18'h00000)
      else $error("weights not cleared by reset");

endmodule : hma_arbiter

// *** verification/hma_req_model.sv ***
// Purpose: Requesting units that sit on the far side of the arbiter
// Assumes: Same clock as the arbiter, requests held as levels
// Notes: A granted unit drops its request for one cycle, then renews it
module hma_req_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] want,
   input wire logic [11:0] gnt,
   output logic [11:0] req
);
   timeunit 1ns;
   timeprecision 1ns;
   // Request follows demand, withdrawn in the cycle after its grant
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         req <= 12'h000;
      else
         req <= want & ~gnt;
   end
endmodule : hma_req_model

// *** verification/tb_hierarchical_memory_arbiter.sv ***
// Purpose: Self-checking bench for the hierarchical memory arbiter
// Assumes: 50 ns clock, APB register access
// Notes: Grant spacing and counts are watched by one monitor process
module tb_hierarchical_memory_arbiter;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0; // Arbiter clock
   logic rst_n = 1'b0; // Reset, active low
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] want = 12'h000; // Demand of each unit
   logic reorder = 1'b0;
   logic ce = 1'b1; // Clock enable, high through reset
   logic [3:0] fault = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, refresh, irq;
   logic [11:0] req, gnt;
   logic [31:0] q; // Last read data
   logic err; // Last error response
   logic ro_d = 1'b0; // Reorder level at the previous edge
   logic prev_cpu = 1'b0; // Last grant went to the processor
   int bad_count = 0;
   int n_compared = 0;
   int gcnt [12]; // Grants per unit
   int total = 0;
   int gap = 1000; // Cycles since last grant or refresh
   int lastgap = 0;
   int need = 20; // Minimum spacing to the next event
   always #25 clk = ~clk;
   hma_arbiter i_dut
   (
      .CLK(clk), .RESET_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .REQ(req), .CPU_REORDER(reorder),
      .RT_FAULT(fault), .GNT(gnt), .REFRESH(refresh), .INT(irq)
   );
   hma_req_model i_units
   (
      .clk(clk), .rst_n(rst_n), .want(want), .gnt(gnt), .req(req)
   );
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Verdict and end of run
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // One APB transfer, held until PREADY is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      bit ok;
      ok = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (int c = 0; c < 50 && !ok; c++)
      begin
         @(posedge clk);
         ok = (pready === 1'b1);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok)
      begin
         bad_count++;
         close_out;
      end
   endtask : apb
   // Wait for n grants under a bound
   task wait_grants(input int n);
      int k;
      k = 0;
      for (int c = 0; c < 2000 && k < n; c++)
      begin
         @(posedge clk);
         if (gnt != 12'h000)
            k++;
      end
      if (k < n)
      begin
         bad_count++;
         close_out;
      end
   endtask : wait_grants
   // Settle a demand pattern, then count grants of one unit
   task ratio(input logic [11:0] w, input int u, input int n, input int exp);
      @(posedge clk);
      want <= w;
      wait_grants(4);
      @(negedge clk);
      foreach (gcnt[i])
         gcnt[i] = 0;
      wait_grants(n);
      @(posedge clk); // Let the monitor's count of the last grant land
      chk(32'(gcnt[u]), 32'(exp));
      $display("test share of unit %0d done", u);
   endtask : ratio
   // Monitor: spacing of grants and refreshes, one-hot grants, counts
   always @(posedge clk)
   begin
      ro_d <= reorder;
      if (!rst_n)
         gap <= 1000;
      else if (gnt != 12'h000 || refresh === 1'b1)
      begin
         chk(32'(gap + 1 >= need), 32'h1);
         chk(32'($onehot0(gnt)), 32'h1);
         lastgap <= gap;
         gap <= 0;
         need <= refresh ? 19 : ((|(gnt & hma_pkg::CPU_GROUP_MASK) && ro_d && !prev_cpu) ? 30 : 20);
         if (gnt != 12'h000)
            prev_cpu <= |(gnt & hma_pkg::CPU_GROUP_MASK);
         for (int i = 0; i < 12; i++)
            if (gnt[i])
            begin
               gcnt[i] <= gcnt[i] + 1;
               total <= total + 1;
            end
      end
      else
         gap <= gap + 1;
   end
   // Main sequence
   initial
   begin
      int k;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, hma_pkg::OFS_WEIGHT, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, hma_pkg::OFS_REFINT, 32'h0);
      chk(q, 32'h138);
      apb(1'b0, 8'h40, 32'h0);
      chk({q[30:0], err}, 32'h1);
      $display("test reset values done");
      apb(1'b1, hma_pkg::OFS_REFINT, 32'h28);
      ratio(12'h008, hma_pkg::U_VIDEO_OUT, 8, 8);
      chk(32'(lastgap), 32'h13);
      reorder <= 1'b1;
      ratio(12'h00a, hma_pkg::U_DCACHE, 8, 4);
      reorder <= 1'b0;
      apb(1'b1, hma_pkg::OFS_WEIGHT, 32'h20000);
      ratio(12'h00a, hma_pkg::U_DCACHE, 8, 6);
      apb(1'b1, hma_pkg::OFS_ENABLE, 32'hff7);
      ratio(12'h00c, hma_pkg::U_ICACHE, 8, 8);
      apb(1'b1, hma_pkg::OFS_ENABLE, 32'hfff);
      apb(1'b1, hma_pkg::OFS_RAISE, 32'h2);
      apb(1'b1, hma_pkg::OFS_RATIO, 32'h4);
      ratio(12'h00a, hma_pkg::U_VIDEO_OUT, 8, 8);
      ratio(12'h180, hma_pkg::U_VLD, 6, 4);
      want <= 12'h000;
      repeat (40) @(posedge clk);
      apb(1'b0, hma_pkg::OFS_BYTES, 32'h0);
      chk(q, 32'(total * 64));
      apb(1'b1, hma_pkg::OFS_INTEN, 32'h1);
      fault <= 4'h3;
      @(posedge clk);
      fault <= 4'h0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, hma_pkg::OFS_STATUS, 32'h0);
      chk(q & 32'hf, 32'h3);
      apb(1'b1, hma_pkg::OFS_INTCLR, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, hma_pkg::OFS_STATUS, 32'h0);
      chk(q & 32'hf, 32'h2);
      $display("test interrupt done");
      apb(1'b1, hma_pkg::OFS_REFINT, 32'h28);
      apb(1'b1, hma_pkg::OFS_INTCLR, 32'h10);
      want <= 12'h008;
      k = 0;
      for (int c = 0; c < 300 && k < 3; c++)
      begin
         @(posedge clk);
         if (refresh === 1'b1)
            k++;
      end
      chk(32'(k), 32'h3);
      apb(1'b0, hma_pkg::OFS_STATUS, 32'h0);
      chk(q & 32'h10, 32'h10);
      $display("test refresh done");
      // Freeze the arbiter just after a grant: nothing may be issued
      wait_grants(1);
      ce <= 1'b0;
      k = 0;
      repeat (40)
      begin
         @(posedge clk);
         if (gnt != 12'h000 || refresh === 1'b1)
            k++;
      end
      ce <= 1'b1;
      chk(32'(k), 32'h0);
      wait_grants(1);
      $display("test clock enable done");
      close_out;
   end
endmodule : tb_hierarchical_memory_arbiter
